// [can_bit_timer.sv]
// Purpose: Time quantum prescaler, bit segment sequencer and bus sampler.
// Assumes: Bus receive input is synchronous to clk.
// Notes: Resynchronizes on recessive to dominant edges within the jump width.
`timescale 1ns/10ps
module can_bit_timer
(
    input wire logic clk,
    input wire logic rst_b,
    input wire can_timing_pkg::timing_prescale_t prescale,
    input wire can_timing_pkg::timing_segments_t segments,
    input wire logic bus_rx,
    output can_timing_pkg::bit_events_t events
);

    typedef enum logic [1:0] {SEG_SYNC, SEG_PRE, SEG_POST} seg_state_t;

    seg_state_t state_reg, state_next;
    logic [5:0] presc_reg, presc_next;
    logic [4:0] qcnt_reg, qcnt_next;
    logic [4:0] pre_len_reg, pre_len_next;
    logic [2:0] votes_reg, votes_next;
    logic rx_prev_reg, rx_prev_next;
    can_timing_pkg::bit_events_t ev_reg, ev_next;
    logic tq_tick;
    logic edge_seen;
    logic [4:0] jump;
    logic [4:0] post_len;
    logic [4:0] post_left;

    // One quantum lasts (prescaler + 1) system clocks.
    assign tq_tick = (presc_reg == prescale.quantum_prescaler);
    assign edge_seen = tq_tick && rx_prev_reg && !bus_rx;
    assign jump = 5'(prescale.resync_jump_width) + 5'd1;
    assign post_len = 5'(segments.post_sample_segment) + 5'd1;
    assign post_left = post_len - qcnt_reg;
    assign events = ev_reg;

    // Segment sequencer with sampling and resynchronization.
    always_comb
    begin
        state_next = state_reg;
        presc_next = tq_tick ? 6'h00 : presc_reg + 6'h01;
        qcnt_next = qcnt_reg;
        pre_len_next = pre_len_reg;
        votes_next = votes_reg;
        rx_prev_next = tq_tick ? bus_rx : rx_prev_reg;
        ev_next = '0;
        ev_next.rx_bit = ev_reg.rx_bit;
        if (tq_tick)
        begin
            case (state_reg)
                SEG_SYNC:
                begin
                    // Sync segment is one quantum long.
                    state_next = SEG_PRE;
                    qcnt_next = 5'h00;
                    pre_len_next = 5'(segments.pre_sample_segment) + 5'd1;
                    ev_next.bit_start = 1'b1;
                end
                SEG_PRE:
                begin
                    // Late edge lengthens the pre sample segment, bounded by the jump width.
                    if (edge_seen)
                        pre_len_next = pre_len_reg + ((qcnt_reg + 5'd1 < jump) ? qcnt_reg + 5'd1 : jump);
                    // Three votes land on the last three quanta before the sample point.
                    votes_next = {votes_reg[1:0], bus_rx};
                    qcnt_next = qcnt_reg + 5'd1;
                    if (qcnt_reg + 5'd1 >= pre_len_reg)
                    begin
                        state_next = SEG_POST;
                        qcnt_next = 5'h00;
                        ev_next.sample_point = 1'b1;
                        if (segments.triple_sample)
                            ev_next.rx_bit = (votes_reg[1] & votes_reg[0]) | (votes_reg[1] & bus_rx)
                                | (votes_reg[0] & bus_rx);
                        else
                            ev_next.rx_bit = bus_rx;
                    end
                end
                SEG_POST:
                begin
                    qcnt_next = qcnt_reg + 5'd1;
                    // Early edge cuts the post sample segment short if within the jump width.
                    if ((qcnt_reg + 5'd1 >= post_len) || (edge_seen && post_left <= jump))
                        state_next = SEG_SYNC;
                end
                default:
                begin
                    state_next = SEG_SYNC;
                end
            endcase
        end
    end

    // Sequencer registers.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_reg <= SEG_SYNC;
            presc_reg <= 6'h00;
            qcnt_reg <= 5'h00;
            pre_len_reg <= 5'h03;
            votes_reg <= 3'h7;
            rx_prev_reg <= 1'b1;
            ev_reg <= 3'h1;
        end
        else
        begin
            state_reg <= state_next;
            presc_reg <= presc_next;
            qcnt_reg <= qcnt_next;
            pre_len_reg <= pre_len_next;
            votes_reg <= votes_next;
            rx_prev_reg <= rx_prev_next;
            ev_reg <= ev_next;
        end
    end

endmodule

// [can_bit_timing_irq.sv]
// Purpose: Bit timing registers, bus bit timer and interrupt source identifier.
// Assumes: Host strobes and engine events are synchronous one cycle pulses.
// Notes: Timing registers have no reset; software must program them.
`timescale 1ns/10ps
module can_bit_timing_irq
#(
    parameter int NUM_OBJ = 15
)
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [7:0] host_addr,
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic [7:0] host_wdata,
    output logic [7:0] host_rdata,
    input wire logic [7:0] status_value,
    input wire logic status_update,
    input wire logic status_change_irq_enable,
    input wire logic global_irq_enable,
    input wire logic [NUM_OBJ-1:0] object_rx_irq_enable,
    input wire logic [NUM_OBJ-1:0] object_tx_irq_enable,
    input wire logic [NUM_OBJ-1:0] object_rx_done,
    input wire logic [NUM_OBJ-1:0] object_tx_done,
    input wire logic [NUM_OBJ-1:0] object_pending_clear,
    output logic [NUM_OBJ-1:0] object_irq_pending,
    input wire logic bus_rx,
    output logic bit_start,
    output logic sample_point,
    output logic rx_bit,
    output logic irq_b
);

    // ************************************************************
    // Elaboration checks
    // ************************************************************
    // Source codes are fixed for fifteen objects; other counts have no encoding.
    generate
        if (NUM_OBJ != can_timing_pkg::NUM_OBJECTS)
        begin : g_bad_count
            $error("NUM_OBJ must be 15");
        end
    endgenerate

    // ************************************************************
    // Host register access
    // ************************************************************
    can_timing_pkg::timing_prescale_t prescale_reg, prescale_next;
    can_timing_pkg::timing_segments_t segments_reg, segments_next;
    logic [7:0] rdata_reg, rdata_next;
    logic [7:0] source_reg, source_next;
    logic wr_prescale;
    logic wr_segments;
    logic status_read;

    assign wr_prescale = host_wr && (host_addr == can_timing_pkg::OFS_TIMING_PRESCALE);
    assign wr_segments = host_wr && (host_addr == can_timing_pkg::OFS_TIMING_SEGMENTS);
    assign status_read = host_rd && (host_addr == can_timing_pkg::OFS_STATUS);
    assign host_rdata = rdata_reg;

    // Timing register next values; writes to the source register are dropped.
    always_comb
    begin
        prescale_next = wr_prescale ? can_timing_pkg::timing_prescale_t'(host_wdata) : prescale_reg;
        segments_next = wr_segments ? can_timing_pkg::timing_segments_t'(host_wdata) : segments_reg;
    end

    // No reset term here, so a hardware reset leaves the programmed timing alone.
    always_ff @(posedge clk)
    begin
        prescale_reg <= prescale_next;
        segments_reg <= segments_next;
    end

    // Read data mux; unmapped offsets answer zero.
    always_comb
    begin
        rdata_next = rdata_reg;
        if (host_rd)
        begin
            case (host_addr)
                can_timing_pkg::OFS_STATUS: rdata_next = status_value;
                can_timing_pkg::OFS_TIMING_PRESCALE: rdata_next = prescale_reg;
                can_timing_pkg::OFS_TIMING_SEGMENTS: rdata_next = segments_reg;
                can_timing_pkg::OFS_IRQ_SOURCE: rdata_next = source_reg;
                default: rdata_next = can_timing_pkg::READ_UNMAPPED;
            endcase
        end
    end

    // Read data register.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            rdata_reg <= 8'h00;
        else
            rdata_reg <= rdata_next;
    end

    // ************************************************************
    // Pending flags
    // ************************************************************
    logic [NUM_OBJ-1:0] pend_reg, pend_next;
    logic status_pend_reg, status_pend_next;

    // One flag per object; a completion that meets a clear in the same cycle wins.
    genvar gi;
    generate
        for (gi = 0; gi < NUM_OBJ; gi = gi + 1)
        begin : g_obj
            logic set_evt;
            assign set_evt = global_irq_enable
                && ((object_rx_done[gi] && object_rx_irq_enable[gi])
                || (object_tx_done[gi] && object_tx_irq_enable[gi]));
            assign pend_next[gi] = set_evt || (pend_reg[gi] && !object_pending_clear[gi]);
        end
    endgenerate

    // A status change while one is already pending merges into the same flag.
    always_comb
    begin
        status_pend_next = status_pend_reg;
        if (status_read)
            status_pend_next = 1'b0;
        if (status_update && status_change_irq_enable)
            status_pend_next = 1'b1;
    end

    // Pending flag registers.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pend_reg <= '0;
            status_pend_reg <= 1'b0;
        end
        else
        begin
            pend_reg <= pend_next;
            status_pend_reg <= status_pend_next;
        end
    end

    assign object_irq_pending = pend_reg;

    // ************************************************************
    // Source code priority and interrupt pin
    // ************************************************************
    logic [7:0] code_now;
    logic [7:0] stage_reg, stage_next;
    logic irq_b_reg, irq_b_next;

    // Lowest code wins: status, then object fifteen, then objects one upward.
    always_comb
    begin
        code_now = can_timing_pkg::CODE_NONE;
        for (int i = NUM_OBJ - 2; i >= 0; i--)
        begin
            if (pend_reg[i])
                code_now = can_timing_pkg::CODE_OBJ_BASE + 8'(i);
        end
        if (pend_reg[NUM_OBJ-1])
            code_now = can_timing_pkg::CODE_OBJ_LAST;
        if (status_pend_reg)
            code_now = can_timing_pkg::CODE_STATUS;
    end

    // One staging register keeps the release latency inside both windows.
    always_comb
    begin
        stage_next = code_now;
        source_next = stage_reg;
        irq_b_next = (stage_reg == can_timing_pkg::CODE_NONE);
    end

    // The staging register is cleared at reset to keep the pin quiet; the source register is cleared to zero as well.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            stage_reg <= 8'h00;
            source_reg <= 8'h00;
            irq_b_reg <= 1'b1;
        end
        else
        begin
            stage_reg <= stage_next;
            source_reg <= source_next;
            irq_b_reg <= irq_b_next;
        end
    end

    assign irq_b = irq_b_reg;

    // ************************************************************
    // Bit timer
    // ************************************************************
    can_timing_pkg::bit_events_t bit_ev;

    // Sampling mode relies on software having lengthened the pre segment.
    can_bit_timer u_bit_timer
    (
        .clk(clk),
        .rst_b(rst_b),
        .prescale(prescale_reg),
        .segments(segments_reg),
        .bus_rx(bus_rx),
        .events(bit_ev)
    );

    assign bit_start = bit_ev.bit_start;
    assign sample_point = bit_ev.sample_point;
    assign rx_bit = bit_ev.rx_bit;

endmodule

// [can_bit_timing_irq_assertions.sv]
// Purpose: Port level checks of the timing registers, bit timer and interrupt source.
// Assumes: One clock domain; host strobes are one cycle pulses.
// Notes: The shadow copies of the timing bytes have no reset, like the registers.
`timescale 1ns/10ps
module can_bit_timing_irq_assertions
#(
    parameter int NUM_OBJ = 15
)
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [7:0] host_addr,
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic [7:0] host_wdata,
    input wire logic [7:0] host_rdata,
    input wire logic [7:0] status_value,
    input wire logic status_update,
    input wire logic status_change_irq_enable,
    input wire logic global_irq_enable,
    input wire logic [NUM_OBJ-1:0] object_rx_irq_enable,
    input wire logic [NUM_OBJ-1:0] object_tx_irq_enable,
    input wire logic [NUM_OBJ-1:0] object_rx_done,
    input wire logic [NUM_OBJ-1:0] object_tx_done,
    input wire logic [NUM_OBJ-1:0] object_pending_clear,
    input wire logic [NUM_OBJ-1:0] object_irq_pending,
    input wire logic bus_rx,
    input wire logic bit_start,
    input wire logic sample_point,
    input wire logic irq_b
);
    // ****************************************
    // Helper state
    // ****************************************
    default clocking dcb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    logic [NUM_OBJ-1:0] set_vec;
    logic stat_reg, stat_next, dirty_reg, dirty_next, seen_reg, seen_next, bus_reg;
    logic [15:0] cnt_reg, cnt_next, q_len, sp_len, bit_len;
    can_timing_pkg::timing_prescale_t tim0_reg, tim0_next;
    can_timing_pkg::timing_segments_t tim1_reg, tim1_next;
    // Set requests that survive the enables, and the expected bit figures.
    assign set_vec = ((object_rx_done & object_rx_irq_enable) | (object_tx_done & object_tx_irq_enable))
        & {NUM_OBJ{global_irq_enable}};
    assign q_len = 16'(tim0_reg.quantum_prescaler) + 16'h0001;
    assign sp_len = q_len * (16'(tim1_reg.pre_sample_segment) + 16'h0001);
    assign bit_len = q_len * (16'(tim1_reg.pre_sample_segment) + 16'(tim1_reg.post_sample_segment) + 16'h0003);
    // Any bus fall or host write spoils the length check of that bit, since resync may move it.
    always_comb
    begin
        stat_next = stat_reg;
        if (host_rd && host_addr == can_timing_pkg::OFS_STATUS)
            stat_next = 1'b0;
        if (status_update && status_change_irq_enable)
            stat_next = 1'b1;
        dirty_next = (bit_start ? 1'b0 : dirty_reg) | (bus_reg & ~bus_rx) | host_wr;
        seen_next = seen_reg | bit_start;
        cnt_next = bit_start ? 16'h0001 : cnt_reg + 16'h0001;
        tim0_next = (host_wr && host_addr == can_timing_pkg::OFS_TIMING_PRESCALE) ? host_wdata : tim0_reg;
        tim1_next = (host_wr && host_addr == can_timing_pkg::OFS_TIMING_SEGMENTS) ? host_wdata : tim1_reg;
    end
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            stat_reg <= 1'b0;
            dirty_reg <= 1'b1;
            seen_reg <= 1'b0;
            bus_reg <= 1'b1;
            cnt_reg <= 16'h0000;
        end
        else
        begin
            stat_reg <= stat_next;
            dirty_reg <= dirty_next;
            seen_reg <= seen_next;
            bus_reg <= bus_rx;
            cnt_reg <= cnt_next;
        end
    end
    always_ff @(posedge clk)
    begin
        tim0_reg <= tim0_next;
        tim1_reg <= tim1_next;
    end
    // ****************************************
    // Properties
    // ****************************************
    property p_rd_prescale;
        host_rd && host_addr == can_timing_pkg::OFS_TIMING_PRESCALE |=> host_rdata == $past(tim0_reg);
    endproperty
    a_rd_prescale: assert property (p_rd_prescale) else $error("prescale byte read back wrong");
    property p_rd_segments;
        host_rd && host_addr == can_timing_pkg::OFS_TIMING_SEGMENTS |=> host_rdata == $past(tim1_reg);
    endproperty
    a_rd_segments: assert property (p_rd_segments) else $error("segment byte read back wrong");
    property p_rd_status;
        host_rd && host_addr == can_timing_pkg::OFS_STATUS |=> host_rdata == $past(status_value);
    endproperty
    a_rd_status: assert property (p_rd_status) else $error("status byte read back wrong");
    property p_pend_set;
        set_vec != '0 |=> (object_irq_pending & $past(set_vec)) == $past(set_vec);
    endproperty
    a_pend_set: assert property (p_pend_set) else $error("pending flag not set");
    property p_pend_cause;
        (object_irq_pending & ~$past(object_irq_pending) & ~$past(set_vec)) == '0;
    endproperty
    a_pend_cause: assert property (p_pend_cause) else $error("pending flag set without cause");
    property p_pend_clear;
        (object_irq_pending & $past(object_pending_clear & ~set_vec)) == '0;
    endproperty
    a_pend_clear: assert property (p_pend_clear) else $error("pending flag not cleared");
    property p_obj_low;
        $rose(|object_irq_pending) |-> ##2 !irq_b;
    endproperty
    a_obj_low: assert property (p_obj_low) else $error("pin not low for object");
    property p_stat_low;
        status_update && status_change_irq_enable |-> ##3 !irq_b;
    endproperty
    a_stat_low: assert property (p_stat_low) else $error("pin not low for status");
    // Window of 3 to 14 cycles after the clearing strobe.
    property p_obj_release;
        object_pending_clear != '0 && (object_irq_pending & ~object_pending_clear) == '0 && set_vec == '0
            && !stat_reg && !status_update && !irq_b |=> !irq_b ##1 !irq_b ##[1:12] irq_b;
    endproperty
    a_obj_release: assert property (p_obj_release) else $error("pin release outside window");
    // Four cycles plus 145 ns at 40 ns gives seven whole cycles.
    property p_stat_release;
        host_rd && host_addr == can_timing_pkg::OFS_STATUS && stat_reg && object_irq_pending == '0
            && set_vec == '0 && !status_update && !irq_b |-> ##[1:7] irq_b;
    endproperty
    a_stat_release: assert property (p_stat_release) else $error("pin late after status read");
    property p_sample_at;
        sample_point && !dirty_reg && seen_reg |-> cnt_reg == sp_len;
    endproperty
    a_sample_at: assert property (p_sample_at) else $error("sample point misplaced");
    property p_bit_len;
        bit_start && !dirty_reg && seen_reg |-> cnt_reg == bit_len;
    endproperty
    a_bit_len: assert property (p_bit_len) else $error("bit length wrong");
    c_bit: cover property (bit_start && !dirty_reg && seen_reg);
    c_rise: cover property ($rose(irq_b));
    c_ack: cover property (host_rd && host_addr == can_timing_pkg::OFS_STATUS && stat_reg);
endmodule
bind can_bit_timing_irq can_bit_timing_irq_assertions #(.NUM_OBJ(NUM_OBJ)) u_chk (.*);

// [can_bit_timing_irq_bench.sv]
// Purpose: Self-checking bench for timing registers, bit timer and interrupt source.
// Assumes: Inputs change by non-blocking assignment at rising edges.
// Notes: Waits of 16 cycles cover the longest pin release of 14 cycles.
`timescale 1ns/10ps
module can_bit_timing_irq_bench;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] host_addr = 8'h00;
    logic [7:0] host_wdata = 8'h00;
    logic host_wr = 1'b0;
    logic host_rd = 1'b0;
    logic status_update = 1'b0;
    logic status_change_irq_enable = 1'b1;
    logic global_irq_enable = 1'b1;
    logic [14:0] rx_en = 15'h7FFF;
    logic [14:0] tx_en = 15'h7FFF;
    logic [14:0] rx_done = 15'h0000;
    logic [14:0] tx_done = 15'h0000;
    logic [14:0] clr = 15'h0000;
    logic [14:0] pending;
    logic [7:0] host_rdata;
    logic [7:0] pattern = 8'hA5;
    logic start = 1'b0;
    logic bus_rx, bit_start, sample_point, rx_bit, irq_b;
    int fail_count = 0;
    int n_compared = 0;
    int i, m;
    can_bus_node_model u_node (.clk(clk), .rst_b(rst_b), .start(start), .pattern(pattern),
        .bit_start(bit_start), .bus_rx(bus_rx));
    can_bit_timing_irq u_dut (.clk(clk), .rst_b(rst_b), .host_addr(host_addr), .host_wr(host_wr),
        .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata), .status_value(8'h5A),
        .status_update(status_update), .status_change_irq_enable(status_change_irq_enable),
        .global_irq_enable(global_irq_enable), .object_rx_irq_enable(rx_en),
        .object_tx_irq_enable(tx_en), .object_rx_done(rx_done), .object_tx_done(tx_done),
        .object_pending_clear(clr), .object_irq_pending(pending), .bus_rx(bus_rx),
        .bit_start(bit_start), .sample_point(sample_point), .rx_bit(rx_bit), .irq_b(irq_b));
    always #20 clk = ~clk;
    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        host_addr <= a;
        host_wdata <= d;
        host_wr <= 1'b1;
        @(posedge clk);
        host_wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        host_addr <= a;
        host_rd <= 1'b1;
        @(posedge clk);
        host_rd <= 1'b0;
        @(negedge clk);
        chk(host_rdata, exp);
    endtask
    // Engine pulses, then a settle time, ending where outputs are stable.
    task automatic ev(input logic [14:0] rx, input logic [14:0] tx, input logic [14:0] c, input logic u);
        @(posedge clk);
        rx_done <= rx;
        tx_done <= tx;
        clr <= c;
        status_update <= u;
        @(posedge clk);
        rx_done <= 15'h0000;
        tx_done <= 15'h0000;
        clr <= 15'h0000;
        status_update <= 1'b0;
        repeat (16) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic wait_ev(input logic sp);
        int n;
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end
        while (((sp ? sample_point : bit_start) !== 1'b1) && n < 400);
        chk(n < 400, 1'b1);
    endtask
    task automatic tally_and_finish();
        if (fail_count == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // ****************************************
    // Sequence
    // ****************************************
    initial
    begin
        #800000;
        fail_count++;
        tally_and_finish();
    end
    initial
    begin
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        wr(8'h3F, 8'h43);
        wr(8'h4F, 8'h25);
        wr(8'h5F, 8'h0E);
        wr(8'h20, 8'hFF);
        rd_chk(8'h5F, 8'h00);
        rd_chk(8'h20, 8'h00);
        // A second reset must leave the timing bytes alone.
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        rd_chk(8'h3F, 8'h43);
        rd_chk(8'h4F, 8'h25);
        ev(15'h2AAA, 15'h5555, 15'h0000, 1'b0);
        chk(pending, 15'h7FFF);
        chk(irq_b, 1'b0);
        for (i = 0; i < 15; i++)
        begin
            rd_chk(8'h5F, (i == 0) ? 8'h02 : 8'(i + 2));
            ev(15'h0000, 15'h0000, 15'h0001 << ((i == 0) ? 14 : i - 1), 1'b0);
        end
        chk(irq_b, 1'b1);
        rd_chk(8'h5F, 8'h00);
        ev(15'h0010, 15'h0000, 15'h0000, 1'b1);
        rd_chk(8'h5F, 8'h01);
        ev(15'h0000, 15'h0000, 15'h0000, 1'b1);
        rd_chk(8'h01, 8'h5A);
        ev(15'h0000, 15'h0000, 15'h0000, 1'b0);
        rd_chk(8'h5F, 8'h07);
        ev(15'h0000, 15'h0000, 15'h0010, 1'b1);
        rd_chk(8'h5F, 8'h01);
        rd_chk(8'h01, 8'h5A);
        ev(15'h0000, 15'h0000, 15'h0000, 1'b0);
        chk(irq_b, 1'b1);
        rd_chk(8'h5F, 8'h00);
        @(posedge clk);
        global_irq_enable <= 1'b0;
        status_change_irq_enable <= 1'b0;
        ev(15'h0001, 15'h0002, 15'h0000, 1'b1);
        chk(pending, 15'h0000);
        rd_chk(8'h5F, 8'h00);
        @(posedge clk);
        global_irq_enable <= 1'b1;
        rx_en <= 15'h0000;
        tx_en <= 15'h0000;
        // Completions with their own object enables off must raise nothing.
        ev(15'h0004, 15'h0008, 15'h0000, 1'b0);
        chk(pending, 15'h0000);
        chk(irq_b, 1'b1);
        // Single sample first, then three samples with two extra quanta ahead of the sample point.
        for (m = 0; m < 2; m++)
        begin
            if (m == 1)
                wr(8'h4F, 8'hA7);
            @(posedge clk);
            start <= 1'b1;
            @(posedge clk);
            start <= 1'b0;
            wait_ev(1'b0);
            for (i = 0; i < 8; i++)
            begin
                wait_ev(1'b1);
                chk(rx_bit, pattern[7 - i]);
            end
        end
        tally_and_finish();
    end
endmodule

// [can_bus_node_model.sv]
// Purpose: Far bus node that sends one byte, most significant bit first.
// Assumes: Recessive level is one; the bus rests recessive between bytes.
// Notes: Bits change just after a bit start, so a fall lands early in the segment.
`timescale 1ns/10ps
module can_bus_node_model
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic start,
    input wire logic [7:0] pattern,
    input wire logic bit_start,
    output logic bus_rx
);
    logic [3:0] left_reg;
    // One bit per bit time, then back to the recessive pull level.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            left_reg <= 4'h0;
            bus_rx <= 1'b1;
        end
        else if (start)
            left_reg <= 4'h8;
        else if (bit_start)
        begin
            bus_rx <= (left_reg != 4'h0) ? pattern[3'(left_reg - 4'h1)] : 1'b1;
            left_reg <= (left_reg != 4'h0) ? left_reg - 4'h1 : 4'h0;
        end
    end
endmodule

// [can_timing_pkg.sv]
// Purpose: Shared constants and types for the CAN bit timing and interrupt source block.
// Assumes: Byte wide host register port, 25 MHz system clock.
// Notes: Field layouts are packed structs laid over the register bytes.
package can_timing_pkg;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] OFS_STATUS = 8'h01;
    localparam logic [7:0] OFS_TIMING_PRESCALE = 8'h3F;
    localparam logic [7:0] OFS_TIMING_SEGMENTS = 8'h4F;
    localparam logic [7:0] OFS_IRQ_SOURCE = 8'h5F;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // ************************************************************
    // Interrupt source codes
    // ************************************************************
    localparam logic [7:0] CODE_NONE = 8'h00;
    localparam logic [7:0] CODE_STATUS = 8'h01;
    localparam logic [7:0] CODE_OBJ_LAST = 8'h02;
    localparam logic [7:0] CODE_OBJ_BASE = 8'h03;
    localparam int NUM_OBJECTS = 15;

    // ************************************************************
    // Timing figures
    // ************************************************************
    localparam int CLK_PERIOD_NS = 40;
    localparam int OBJ_RELEASE_MIN_CYC = 3;
    localparam int OBJ_RELEASE_MAX_CYC = 14;
    localparam int STATUS_EXTRA_NS = 145;
    // Longest time, so the division rounds down.
    localparam int STATUS_EXTRA_CYC = STATUS_EXTRA_NS / CLK_PERIOD_NS;
    localparam int STATUS_RELEASE_MAX_CYC = 4 + STATUS_EXTRA_CYC;
    // Edges from a clear strobe to the new source code and pin level.
    localparam int SRC_LATENCY_CYC = 3;
    localparam int SYNC_SEG_QUANTA = 1;
    localparam int TRIPLE_EXTRA_QUANTA = 2;

    // ************************************************************
    // Register field layouts
    // ************************************************************
    typedef struct packed {
        logic [1:0] resync_jump_width;
        logic [5:0] quantum_prescaler;
    } timing_prescale_t;

    typedef struct packed {
        logic triple_sample;
        logic [2:0] post_sample_segment;
        logic [3:0] pre_sample_segment;
    } timing_segments_t;

    // Bit timer status strobes travel together.
    typedef struct packed {
        logic bit_start;
        logic sample_point;
        logic rx_bit;
    } bit_events_t;

endpackage
